// ===== hw/reader_end.sv
`timescale 1ns/100ps
`include "tag_defs.svh"
module reader_end
  import tag_pkg::*;
(
  // System clock and reset
  input wire logic clk,
  input wire logic rst,
  // Air link; this end makes the link clock
  tag_link_if.reader link,
  // Request from the user, up to six bytes, byte 0 first
  input wire logic req_valid,
  input wire logic [3:0] req_len,
  input wire logic [47:0] req_bytes,
  output logic req_ready,
  // Answer to the user, length zero means silence
  output logic rsp_valid,
  output logic [3:0] rsp_len,
  output logic [63:0] rsp_bytes,
  output logic rsp_crc_ok
);

  // ==========================================
  // Link clock divider; request bits change as the clock falls
  logic [2:0] cnt_q;
  logic link_clk_q;
  wire tick_out = cnt_q == 3'(`LINK_HALF - 1);
  // Late sample leaves room for the three-stage synchroniser
  wire tick_in = cnt_q == 3'(`LINK_DIV - 2);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 3'd0;
      link_clk_q <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == 3'(`LINK_DIV - 1)) ? 3'd0 : cnt_q + 3'd1;
      link_clk_q <= (cnt_q == 3'(`LINK_DIV - 1)) ? 1'b1 : tick_out ? 1'b0 : link_clk_q;
    end
  end

  // ==========================================
  // Answer lines come from the link domain
  logic [2:0] sd_q;
  logic [2:0] sf_q;
  logic fd_q;
  logic ff_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sd_q <= 3'b000;
      sf_q <= 3'b000;
      fd_q <= 1'b0;
      ff_q <= 1'b0;
    end else begin
      sd_q <= {sd_q[1:0], link.rsp_data};
      sf_q <= {sf_q[1:0], link.rsp_frame};
      fd_q <= (sd_q[1] == sd_q[2]) ? sd_q[2] : fd_q;
      ff_q <= (sf_q[1] == sf_q[2]) ? sf_q[2] : ff_q;
    end
  end

  // ==========================================
  // Request serialiser
  reader_phase_type phase_q;
  logic [47:0] t_data_q;
  logic [3:0] t_len_q;
  logic [3:0] t_bit_q;
  logic [3:0] t_idx_q;
  logic [8:0] t_sh_q;
  logic [15:0] t_crc_q;
  logic req_data_q;
  logic req_frame_q;
  wire accept = phase_q == r_idle && req_valid && req_ready;
  wire send_tick = phase_q == r_send && tick_out;
  wire [7:0] t_byte = (t_idx_q < t_len_q) ? t_data_q[6'(t_idx_q * 4'd8) +: 8]
    : (t_idx_q == t_len_q) ? ~t_crc_q[7:0] : ~t_crc_q[15:8];
  wire t_char_end = t_bit_q == 4'd0 || t_bit_q == 4'd10;
  wire t_done = send_tick && t_char_end && t_idx_q == t_len_q + 4'd2;

  // Frame is data characters then two check bytes, low byte first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      t_data_q <= 48'h0000_0000_0000;
      t_len_q <= 4'd0;
      t_bit_q <= 4'd0;
      t_idx_q <= 4'd0;
      t_sh_q <= 9'h000;
      t_crc_q <= `CRC_INIT;
      req_data_q <= 1'b0;
      req_frame_q <= 1'b0;
    end else if (accept) begin
      t_data_q <= req_bytes;
      t_len_q <= req_len;
    end else if (t_done) begin
      req_frame_q <= 1'b0;
      req_data_q <= 1'b0;
      t_bit_q <= 4'd0;
      t_idx_q <= 4'd0;
      t_crc_q <= `CRC_INIT;
    end else if (send_tick && t_char_end) begin
      req_frame_q <= 1'b1;
      req_data_q <= 1'b0;
      t_sh_q <= {1'b1, t_byte};
      t_bit_q <= 4'd1;
      t_idx_q <= t_idx_q + 4'd1;
      if (t_idx_q < t_len_q) begin
        t_crc_q <= crc_step(t_crc_q, t_byte);
      end
    end else if (send_tick) begin
      req_data_q <= t_sh_q[0];
      t_sh_q <= {1'b0, t_sh_q[8:1]};
      t_bit_q <= t_bit_q + 4'd1;
    end
  end

  // ==========================================
  // Answer deserialiser and phase control
  logic [6:0] wait_q;
  logic [3:0] r_bit_q;
  logic [3:0] r_cnt_q;
  logic [8:0] r_sh_q;
  logic [15:0] r_crc_q;
  wire [9:0] r_char = {fd_q, r_sh_q};
  wire take_bit = tick_in && ff_q && (phase_q == r_wait || phase_q == r_recv);
  wire r_byte = take_bit && r_bit_q == 4'd9;
  wire timeout = tick_in && phase_q == r_wait && !ff_q && wait_q == 7'(`RSP_WAIT_BITS - 1);
  wire r_done = (tick_in && phase_q == r_recv && !ff_q) || timeout;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_q <= 7'd0;
      r_bit_q <= 4'd0;
      r_cnt_q <= 4'd0;
      r_sh_q <= 9'h000;
      r_crc_q <= `CRC_INIT;
    end else if (accept) begin
      wait_q <= 7'd0;
      r_bit_q <= 4'd0;
      r_cnt_q <= 4'd0;
      r_crc_q <= `CRC_INIT;
    end else if (take_bit) begin
      r_sh_q <= r_char[9:1];
      r_bit_q <= r_byte ? 4'd0 : r_bit_q + 4'd1;
      if (r_byte && r_cnt_q != 4'hF) begin
        r_cnt_q <= r_cnt_q + 4'd1;
        r_crc_q <= crc_step(r_crc_q, r_char[8:1]);
      end
    end else if (tick_in && phase_q == r_wait) begin
      wait_q <= wait_q + 7'd1;
    end
  end

  // Phase and user-facing outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_q <= r_idle;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_len <= 4'd0;
      rsp_bytes <= 64'h0000_0000_0000_0000;
      rsp_crc_ok <= 1'b0;
    end else begin
      rsp_valid <= r_done;
      req_ready <= (phase_q == r_idle && !accept) || r_done;
      if (accept) begin
        phase_q <= r_send;
        rsp_bytes <= 64'h0000_0000_0000_0000;
      end else if (t_done) begin
        phase_q <= r_wait;
      end else if (take_bit && phase_q == r_wait) begin
        phase_q <= r_recv;
      end else if (r_done) begin
        phase_q <= r_idle;
        rsp_len <= (r_cnt_q >= 4'd2) ? r_cnt_q - 4'd2 : 4'd0;
        rsp_crc_ok <= r_cnt_q >= 4'd3 && r_bit_q == 4'd0 && r_crc_q == `CRC_RESIDUE;
      end
      if (r_byte && r_cnt_q < 4'd8) begin
        rsp_bytes[{r_cnt_q[2:0], 3'b000} +: 8] <= r_char[8:1];
      end
    end
  end

  assign link.link_clk = link_clk_q;
  assign link.req_data = req_data_q;
  assign link.req_frame = req_frame_q;

endmodule // reader_end

// ===== hw/tag_defs.svh
`ifndef TAG_DEFS_SVH
`define TAG_DEFS_SVH

// ==========================================
// Character and frame layout
`define CHAR_BITS 10
`define RX_MAX 8
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'h8408
`define CRC_RESIDUE 16'hF0B8
`define LFSR_SEED 8'hA5

// ==========================================
// Command codes, first data character
`define CMD_BEGIN_CENSUS 8'h10
`define CMD_SLOT_ZERO_POLL 8'h11
`define CMD_SLOT_ADVANCE 8'h12
`define CMD_PICK 8'h13
`define CMD_RETIRE_TAG 8'h14
`define CMD_SERIAL_FETCH 8'h15
`define CMD_BLOCK_READ 8'h16
`define CMD_BLOCK_WRITE 8'h17

// ==========================================
// Link timing on the reader side
`define CLK_NS 10
`define LINK_NS 80
`define LINK_DIV (`LINK_NS / `CLK_NS)
`define LINK_HALF (`LINK_DIV / 2)
`define RSP_WAIT_BITS 64

`endif

// ===== hw/tag_end.sv
`timescale 1ns/100ps
`include "tag_defs.svh"
// What this block does
// - Characters are ten bits, start bit first
// - Reader frames data, two check bytes, end
// - Bad command or check: stay silent
// - Replies framed, two check bytes before end
// - Power-up: reset, random code, ready state
// - Ready plus begin census enters census
// - Census answers census commands, stays there
// - Census pick with matching code selects
// - Selected runs memory commands, ignores census
// - Selected pick with other code parks
// - Selected retire command retires tag
// - Parked returns only on matching pick
// - Retired ignores all until power loss
// - Reader keeps one tag selected only
// - Code refreshed at power-up and census restart
// - Slot index is code low nibble
// - Slot zero poll redraws, answers on zero
// - Slot advance answers on slot match
// - Reader opens sixteen slots in order
// - Begin census answers immediately
// - Fixed code option replaces random code
module tag_end
  import tag_pkg::*;
#(
  parameter logic [63:0] SERIAL_NUMBER = 64'h0000_0000_0000_0001  // Arbitrary value
) (
  // Air link, clocked by the link clock
  tag_link_if.tag link,
  // Field power-up reset
  input wire logic rst,
  // Fixed code option straps
  input wire logic fixed_code_en,
  input wire logic [7:0] fixed_code,
  // Block memory port
  output logic [7:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic mem_we,
  input wire logic [31:0] mem_rdata,
  // Observed state
  output tag_state_type state,
  output logic [7:0] select_code
);

  // ==========================================
  // Receive side
  logic frame_q;
  logic [3:0] bit_cnt_q;
  logic [8:0] sh_q;
  logic [7:0] rx_buf [0:`RX_MAX-1];
  logic [3:0] rx_cnt_q;
  logic rx_err_q;
  logic [15:0] rx_crc_q;
  wire [9:0] char_w = {link.req_data, sh_q};
  wire char_done = link.req_frame && (bit_cnt_q == 4'd9);
  wire char_bad = char_w[0] || !char_w[9];
  wire frame_end = frame_q && !link.req_frame;

  // Bit counter restarts whenever the frame line drops
  always_ff @(posedge link.link_clk or posedge rst) begin
    if (rst) begin
      frame_q <= 1'b0;
      bit_cnt_q <= 4'd0;
      sh_q <= 9'h000;
    end else begin
      frame_q <= link.req_frame;
      bit_cnt_q <= (link.req_frame && !char_done) ? bit_cnt_q + 4'd1 : 4'd0;
      if (link.req_frame) begin
        sh_q <= char_w[9:1];
      end
    end
  end

  always_ff @(posedge link.link_clk or posedge rst) begin
    if (rst) begin
      rx_cnt_q <= 4'd0;
      rx_err_q <= 1'b0;
      rx_crc_q <= `CRC_INIT;
    end else if (frame_end) begin
      rx_cnt_q <= 4'd0;
      rx_err_q <= 1'b0;
      rx_crc_q <= `CRC_INIT;
    end else if (char_done) begin
      if (char_bad || rx_cnt_q == 4'(`RX_MAX)) begin
        rx_err_q <= 1'b1;
      end else begin
        rx_cnt_q <= rx_cnt_q + 4'd1;
        rx_crc_q <= crc_step(rx_crc_q, char_w[8:1]);
      end
    end
  end

  // Frame store needs no reset; only counted entries are read
  always_ff @(posedge link.link_clk) begin
    if (char_done && !char_bad && rx_cnt_q < 4'(`RX_MAX)) begin
      rx_buf[rx_cnt_q[2:0]] <= char_w[8:1];
    end
  end

  // ==========================================
  // Decode at the end of a frame
  wire [7:0] cmd = rx_buf[0];
  wire [7:0] arg = rx_buf[1];
  wire two_byte = (cmd == `CMD_SLOT_ADVANCE) || (cmd == `CMD_PICK) || (cmd == `CMD_BLOCK_READ);
  wire [3:0] need_len = two_byte ? 4'd2 : (cmd == `CMD_BLOCK_WRITE) ? 4'd6 : 4'd1;
  // wrong length, framing or check drops the frame
  wire frame_ok = frame_end && !rx_err_q && bit_cnt_q == 4'd0
    && rx_cnt_q == need_len + 4'd2 && rx_crc_q == `CRC_RESIDUE;
  wire in_ready = state == ready_state;
  wire in_census = state == census_state;
  wire in_sel = state == selected_state;
  wire in_park = state == parked_state;
  // each command only in the states that accept it
  wire do_begin = frame_ok && cmd == `CMD_BEGIN_CENSUS && (in_ready || in_census);
  wire do_poll = frame_ok && cmd == `CMD_SLOT_ZERO_POLL && in_census;
  wire do_adv = frame_ok && cmd == `CMD_SLOT_ADVANCE && in_census;
  wire do_pick = frame_ok && cmd == `CMD_PICK && (in_census || in_sel || in_park);
  wire do_retire = frame_ok && cmd == `CMD_RETIRE_TAG && in_sel;
  wire do_serial = frame_ok && cmd == `CMD_SERIAL_FETCH && in_sel;
  wire do_read = frame_ok && cmd == `CMD_BLOCK_READ && in_sel;
  wire do_write = frame_ok && cmd == `CMD_BLOCK_WRITE && in_sel;
  wire code_hit = arg == select_code;

  // ==========================================
  // Select code and random source
  logic [7:0] lfsr_q;
  logic boot_q;
  logic fixed_q;
  // a fixed code never changes after power-up
  wire [7:0] new_code = fixed_q ? select_code : lfsr_q;
  // slot index lives in the low nibble
  wire [3:0] new_slot = fixed_q ? select_code[3:0] : lfsr_q[3:0];
  // load at power-up, refresh on census restart
  wire [7:0] code_d = boot_q ? (fixed_code_en ? fixed_code : lfsr_q)
    : (do_begin && in_census) ? new_code
    : do_poll ? {select_code[7:4], new_slot} : select_code;
  // which frames earn a code answer
  wire rep_code = do_begin || (do_poll && new_slot == 4'h0)
    || (do_adv && arg[3:0] == select_code[3:0]);

  // Free-running shift register; strap is sampled on the first edge after reset
  always_ff @(posedge link.link_clk or posedge rst) begin
    if (rst) begin
      lfsr_q <= `LFSR_SEED;
      boot_q <= 1'b1;
      fixed_q <= 1'b0;
      select_code <= 8'h00;
    end else begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      boot_q <= 1'b0;
      if (boot_q) begin
        fixed_q <= fixed_code_en;
      end
      select_code <= code_d;
    end
  end

  // ==========================================
  // State machine
  tag_state_type state_d;
  always_comb begin
    state_d = state;
    unique case (state)
      ready_state: if (do_begin) begin
        state_d = census_state;
      end
      census_state: if (do_pick && code_hit) begin
        state_d = selected_state;
      end
      selected_state: if (do_retire) begin
        state_d = retired_state;
      end else if (do_pick && !code_hit) begin
        state_d = parked_state;
      end
      parked_state: if (do_pick && code_hit) begin
        state_d = selected_state;
      end
      retired_state: state_d = retired_state;
      default: state_d = ready_state;
    endcase
  end

  always_ff @(posedge link.link_clk or posedge rst) begin
    if (rst) begin
      state <= ready_state;
    end else begin
      state <= state_d;
    end
  end

  // ==========================================
  // Memory port; read data returns one cycle later
  logic rd_pend_q;
  always_ff @(posedge link.link_clk or posedge rst) begin
    if (rst) begin
      mem_addr <= 8'h00;
      mem_wdata <= 32'h0000_0000;
      mem_we <= 1'b0;
      rd_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= do_read;
      mem_we <= do_write;
      if (do_read || do_write) begin
        mem_addr <= arg;
      end
      if (do_write) begin
        mem_wdata <= {rx_buf[5], rx_buf[4], rx_buf[3], rx_buf[2]};
      end
    end
  end

  // ==========================================
  // Reply loader
  logic [63:0] tx_data_q;
  logic [3:0] tx_len_q;
  logic tx_start_q;
  always_ff @(posedge link.link_clk or posedge rst) begin
    if (rst) begin
      tx_data_q <= 64'h0000_0000_0000_0000;
      tx_len_q <= 4'd0;
      tx_start_q <= 1'b0;
    end else begin
      tx_start_q <= rep_code || do_serial || rd_pend_q;
      if (rep_code) begin
        tx_data_q <= {56'h0, code_d};
        tx_len_q <= 4'd1;
      end else if (do_serial) begin
        tx_data_q <= SERIAL_NUMBER;
        tx_len_q <= 4'd8;
      end else if (rd_pend_q) begin
        tx_data_q <= {32'h0, mem_rdata};
        tx_len_q <= 4'd4;
      end
    end
  end

  // ==========================================
  // Reply serialiser, ten link cycles per character
  logic tx_busy_q;
  logic [3:0] tx_bit_q;
  logic [3:0] tx_idx_q;
  logic [8:0] tx_sh_q;
  logic [15:0] tx_crc_q;
  logic rsp_data_q;
  logic rsp_frame_q;
  wire [3:0] tx_total = tx_len_q + 4'd2;
  // data bytes, then check low and high bytes
  wire [7:0] tx_byte = (tx_idx_q < tx_len_q) ? tx_data_q[{tx_idx_q[2:0], 3'b000} +: 8]
    : (tx_idx_q == tx_len_q) ? ~tx_crc_q[7:0] : ~tx_crc_q[15:8];
  wire tx_step = tx_busy_q && tx_bit_q == 4'd10;
  wire tx_load = tx_start_q || (tx_step && tx_idx_q != tx_total);

  // start bit first, data low bit first, stop bit last
  always_ff @(posedge link.link_clk or posedge rst) begin
    if (rst) begin
      tx_busy_q <= 1'b0;
      tx_bit_q <= 4'd0;
      tx_idx_q <= 4'd0;
      tx_sh_q <= 9'h000;
      tx_crc_q <= `CRC_INIT;
      rsp_data_q <= 1'b0;
      rsp_frame_q <= 1'b0;
    end else if (tx_load) begin
      tx_busy_q <= 1'b1;
      rsp_frame_q <= 1'b1;
      rsp_data_q <= 1'b0;
      tx_sh_q <= {1'b1, tx_byte};
      tx_bit_q <= 4'd1;
      tx_idx_q <= tx_idx_q + 4'd1;
      if (tx_idx_q < tx_len_q) begin
        tx_crc_q <= crc_step(tx_crc_q, tx_byte);
      end
    end else if (tx_step) begin
      tx_busy_q <= 1'b0;
      rsp_frame_q <= 1'b0;
      rsp_data_q <= 1'b0;
      tx_idx_q <= 4'd0;
      tx_crc_q <= `CRC_INIT;
    end else if (tx_busy_q) begin
      rsp_data_q <= tx_sh_q[0];
      tx_sh_q <= {1'b0, tx_sh_q[8:1]};
      tx_bit_q <= tx_bit_q + 4'd1;
    end
  end

  assign link.rsp_data = rsp_data_q;
  assign link.rsp_frame = rsp_frame_q;

endmodule // tag_end

// ===== hw/tag_link_if.sv
`timescale 1ns/100ps
// ==========================================
// Air link, bit serial, framed by level
interface tag_link_if;
  logic link_clk;
  logic req_data;
  logic req_frame;
  logic rsp_data;
  logic rsp_frame;

  modport tag (input link_clk, input req_data, input req_frame,
    output rsp_data, output rsp_frame);
  modport reader (output link_clk, output req_data, output req_frame,
    input rsp_data, input rsp_frame);
endinterface // tag_link_if

// ===== hw/tag_pkg.sv
package tag_pkg;
`include "tag_defs.svh"

  // ==========================================
  // Types
  typedef enum logic [4:0] {
    ready_state = 5'b0_0001,
    census_state = 5'b0_0010,
    selected_state = 5'b0_0100,
    parked_state = 5'b0_1000,
    retired_state = 5'b1_0000
  } tag_state_type;

  typedef enum logic [3:0] {
    r_idle = 4'b0001,
    r_send = 4'b0010,
    r_wait = 4'b0100,
    r_recv = 4'b1000
  } reader_phase_type;

  // One byte of the reflected frame check, low bit first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ `CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

endpackage

// ===== verification/tag_link_assertions.sv
`timescale 1ns/100ps
// ==========================================
// Link checker, link clock domain only
module tag_link_assertions (
  // Link clock and field reset
  input wire logic link_clk,
  input wire logic rst,
  // Reader to tag
  input wire logic req_data,
  input wire logic req_frame,
  // Tag to reader
  input wire logic rsp_data,
  input wire logic rsp_frame
);
  logic [7:0] qc_q;
  logic [7:0] ac_q;

  // Bit counters within a frame; position in a character is the count mod 10
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      qc_q <= 8'h00;
      ac_q <= 8'h00;
    end else begin
      qc_q <= req_frame ? qc_q + 8'h01 : 8'h00;
      ac_q <= rsp_frame ? ac_q + 8'h01 : 8'h00;
    end
  end

  default clocking dc @(posedge link_clk);
  endclocking
  default disable iff (rst);

  // ==========================================
  // Character and frame shape
  req_start_bit_a: assert property (req_frame && qc_q % 10 == 0 |-> !req_data)
    else $error("request start bit not low");
  req_stop_bit_a: assert property (req_frame && qc_q % 10 == 9 |-> req_data)
    else $error("request stop bit not high");
  req_frame_len_a: assert property ($fell(req_frame) |-> qc_q % 10 == 0 && qc_q >= 30)
    else $error("request frame not whole characters plus check");
  rsp_start_bit_a: assert property (rsp_frame && ac_q % 10 == 0 |-> !rsp_data)
    else $error("answer start bit not low");
  rsp_stop_bit_a: assert property (rsp_frame && ac_q % 10 == 9 |-> rsp_data)
    else $error("answer stop bit not high");
  rsp_frame_len_a: assert property ($fell(rsp_frame) |-> ac_q % 10 == 0 && ac_q >= 30)
    else $error("answer frame not whole characters plus check");

  // ==========================================
  // Turnaround: an answer only follows a request end, and never overlaps it
  rsp_after_req_a: assert property ($rose(rsp_frame) |->
    ($past(req_frame, 3) && !$past(req_frame, 2)) ||
    ($past(req_frame, 4) && !$past(req_frame, 3)))
    else $error("answer frame not two or three bits after request end");
  half_duplex_a: assert property (!(req_frame && rsp_frame))
    else $error("request and answer frames overlap");
endmodule // tag_link_assertions

// ===== verification/tb.sv
`timescale 1ns/100ps
`include "tag_defs.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR at %0t: got %h expected %h", $time, (g), (e)); end end
// ==========================================
// Reader end and tag end joined across one link
module tb;
  import tag_pkg::*;
  logic clk = 1'b0;
  // Starts low so the first reset is a true rising edge for both ends
  logic rst = 1'b0;
  logic fixed_code_en = 1'b0;
  logic [7:0] fixed_code = 8'h00;
  logic req_valid = 1'b0;
  logic [3:0] req_len = 4'h1;
  logic [47:0] req_bytes = 48'h0000_0000_0000;
  logic req_ready;
  logic rsp_valid;
  logic [3:0] rsp_len;
  logic [63:0] rsp_bytes;
  logic rsp_crc_ok;
  logic [7:0] mem_addr;
  logic [31:0] mem_wdata;
  logic mem_we;
  logic [31:0] mem_rdata;
  tag_state_type state;
  logic [7:0] select_code;
  logic [7:0] we_addr;
  logic [31:0] we_data;
  int bad_count = 0;
  int cmp_count = 0;
  int we_count = 0;

  tag_link_if lnk();

  reader_end i_reader_end (.clk(clk), .rst(rst), .link(lnk.reader), .req_valid(req_valid),
    .req_len(req_len), .req_bytes(req_bytes), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_len(rsp_len), .rsp_bytes(rsp_bytes), .rsp_crc_ok(rsp_crc_ok));

  // Serial value is arbitrary
  tag_end #(.SERIAL_NUMBER(64'h0123_4567_89ab_cdef)) i_tag_end (.link(lnk.tag), .rst(rst),
    .fixed_code_en(fixed_code_en), .fixed_code(fixed_code), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rdata(mem_rdata), .state(state),
    .select_code(select_code));

  tag_link_assertions i_tag_link_assertions (.link_clk(lnk.link_clk), .rst(rst),
    .req_data(lnk.req_data), .req_frame(lnk.req_frame), .rsp_data(lnk.rsp_data),
    .rsp_frame(lnk.rsp_frame));

  // Memory stand-in: data depends on address so a wrong address shows
  assign mem_rdata = {mem_addr, ~mem_addr, 16'h5a5a};

  // Write strobe monitor, counts every link cycle the strobe is seen
  always @(posedge lnk.link_clk) begin
    if (mem_we === 1'b1) begin
      we_count++;
      we_addr = mem_addr;
      we_data = mem_wdata;
    end
  end

  initial begin
    forever #5 clk = ~clk;
  end

  // ==========================================
  // Shared tasks
  task automatic power_up(input logic en, input logic [7:0] code);
    @(posedge clk);
    rst <= 1'b1;
    fixed_code_en <= en;
    fixed_code <= code;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // Give the tag a few link edges before the first frame
    repeat (40) @(posedge clk);
  endtask

  // One request and its answer; bounded so a silent hang is caught
  task automatic xfer(input logic [3:0] n, input logic [47:0] b);
    int w;
    w = 0;
    while (req_ready !== 1'b1 && w < 4000) begin
      @(negedge clk);
      w++;
    end
    @(posedge clk);
    req_valid <= 1'b1;
    req_len <= n;
    req_bytes <= b;
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    while (rsp_valid !== 1'b1 && w < 4000) begin
      @(negedge clk);
      w++;
    end
    if (w >= 4000) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, w, 4000);
    end
  endtask

  task automatic expect_rsp(input logic [3:0] n, input logic [7:0] b0, input tag_state_type st);
    `CHK(rsp_len, n)
    if (n != 4'h0) begin
      `CHK(rsp_crc_ok, 1'b1)
      `CHK(rsp_bytes[7:0], b0)
    end
    `CHK(state, st)
  endtask

  // ==========================================
  // Scenarios
  task automatic t_ready;
    xfer(4'h1, {40'h0, `CMD_SLOT_ZERO_POLL});
    expect_rsp(4'h0, 8'h00, ready_state);
    xfer(4'h1, {40'h0, `CMD_RETIRE_TAG});
    expect_rsp(4'h0, 8'h00, ready_state);
    xfer(4'h1, {40'h0, `CMD_BEGIN_CENSUS});
    expect_rsp(4'h1, select_code, census_state);
    $display("test ready done");
  endtask

  task automatic t_census;
    logic [7:0] code;
    int hits;
    xfer(4'h1, {40'h0, `CMD_BEGIN_CENSUS});
    expect_rsp(4'h1, select_code, census_state);
    code = select_code;
    // Unknown command: silence and the code is left alone
    xfer(4'h1, {40'h0, 8'h20});
    expect_rsp(4'h0, 8'h00, census_state);
    `CHK(select_code, code)
    xfer(4'h2, {32'h0, 4'h0, code[3:0], `CMD_SLOT_ADVANCE});
    expect_rsp(4'h1, code, census_state);
    xfer(4'h2, {32'h0, 4'h0, ~code[3:0], `CMD_SLOT_ADVANCE});
    expect_rsp(4'h0, 8'h00, census_state);
    for (int i = 0; i < 4; i++) begin
      xfer(4'h1, {40'h0, `CMD_SLOT_ZERO_POLL});
      `CHK(rsp_len, (select_code[3:0] == 4'h0) ? 4'h1 : 4'h0)
    end
    // Full sweep of sixteen slots: the tag holds one slot index, so one answer
    hits = 0;
    xfer(4'h1, {40'h0, `CMD_SLOT_ZERO_POLL});
    hits += rsp_len;
    for (int s = 1; s < 16; s++) begin
      xfer(4'h2, {32'h0, 4'h0, 4'(s), `CMD_SLOT_ADVANCE});
      hits += rsp_len;
    end
    `CHK(hits, 1)
    $display("test census done");
  endtask

  task automatic t_fixed;
    xfer(4'h1, {40'h0, `CMD_BEGIN_CENSUS});
    expect_rsp(4'h1, 8'h30, census_state);
    xfer(4'h1, {40'h0, `CMD_SLOT_ZERO_POLL});
    expect_rsp(4'h1, 8'h30, census_state);
    xfer(4'h2, {32'h0, 8'h05, `CMD_SLOT_ADVANCE});
    expect_rsp(4'h0, 8'h00, census_state);
    xfer(4'h2, {32'h0, 8'h31, `CMD_PICK});
    expect_rsp(4'h0, 8'h00, census_state);
    xfer(4'h2, {32'h0, 8'h30, `CMD_PICK});
    expect_rsp(4'h0, 8'h00, selected_state);
    $display("test fixed code done");
  endtask

  task automatic t_selected;
    xfer(4'h1, {40'h0, `CMD_BEGIN_CENSUS});
    expect_rsp(4'h0, 8'h00, selected_state);
    xfer(4'h1, {40'h0, `CMD_SERIAL_FETCH});
    `CHK({rsp_len, rsp_bytes}, {4'h8, 64'h0123_4567_89ab_cdef})
    `CHK(rsp_crc_ok, 1'b1)
    xfer(4'h6, {32'hdead_beef, 8'h07, `CMD_BLOCK_WRITE});
    `CHK({we_count, we_addr, we_data}, {32'h1, 8'h07, 32'hdead_beef})
    xfer(4'h2, {32'h0, 8'h09, `CMD_BLOCK_READ});
    `CHK({rsp_len, rsp_crc_ok, rsp_bytes[31:0]}, {4'h4, 1'b1, 32'h09f6_5a5a})
    // picking another code parks this tag
    xfer(4'h2, {32'h0, 8'h31, `CMD_PICK});
    expect_rsp(4'h0, 8'h00, parked_state);
    $display("test selected done");
  endtask

  task automatic t_parked;
    xfer(4'h1, {40'h0, `CMD_SERIAL_FETCH});
    expect_rsp(4'h0, 8'h00, parked_state);
    xfer(4'h2, {32'h0, 8'h35, `CMD_PICK});
    expect_rsp(4'h0, 8'h00, parked_state);
    xfer(4'h2, {32'h0, 8'h30, `CMD_PICK});
    expect_rsp(4'h0, 8'h00, selected_state);
    xfer(4'h1, {40'h0, `CMD_RETIRE_TAG});
    expect_rsp(4'h0, 8'h00, retired_state);
    xfer(4'h2, {32'h0, 8'h30, `CMD_PICK});
    expect_rsp(4'h0, 8'h00, retired_state);
    xfer(4'h1, {40'h0, `CMD_BEGIN_CENSUS});
    expect_rsp(4'h0, 8'h00, retired_state);
    $display("test parked and retired done");
  endtask

  // ==========================================
  // Verdict, reached from the main sequence or the watchdog
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Roughly 45 transfers of under 1500 cycles each
  initial begin
    #800_000;
    bad_count++;
    complete_run();
  end

  initial begin
    power_up(1'b0, 8'h00);
    t_ready();
    t_census();
    power_up(1'b1, 8'h30);
    t_fixed();
    t_selected();
    t_parked();
    complete_run();
  end
endmodule // tb
